// File: hw/pwm_gpio_pkg.sv
// Function
// R1: sixteen channels, each individually selectable as PWM or general-purpose pin.
// R2: each general-purpose channel is either input or output.
// R3: general-purpose output states: steady high, steady low, high pulse, low pulse.
// R4: steady low holds zero until another state is commanded.
// R5: high pulse drives one for exactly the configured width.
// R6: low pulse drives zero for exactly the configured width.
// R7: each PWM channel holds lower and upper pulse-width limits.
// R8: position mode width is a percentage placed between the two limits.
// R9: duty mode width is a percentage of the period.
// R10: duty mode full scale drives one continuously.
// R11: duty mode zero drives zero continuously.
// R12: the frequency setting sets the pulse repetition period.
// R13: channels share one period per fixed pair, 1-2 up to 15-16.
// R14: each PWM channel takes the command of its selected actuator.
// R15: times are counted in block clock cycles through a microsecond tick.
// R16: after a single pulse the output rests at the opposite level.
package pwm_gpio_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int NUM_PAIR = NUM_CH / 2;
  localparam int TIME_W = 16;
  localparam int PCT_W = 16;
  localparam int SEL_W = 4;
  localparam int CFG_W = 12;
  localparam int ADDR_W = 12;
  localparam logic [PCT_W-1:0] PCT_FULL = 16'h2710;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int CH_STRIDE = 16;
  localparam int OFS_CFG = 0;
  localparam int OFS_LO = 4;
  localparam int OFS_HI = 8;
  localparam int OFS_WIDTH = 12;
  localparam logic [ADDR_W-1:0] CMD_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] PERIOD_BASE = 12'h140;
  localparam logic [ADDR_W-1:0] PIN_IN_ADDR = 12'h160;
  localparam logic [ADDR_W-1:0] PIN_OUT_ADDR = 12'h164;
  localparam logic [ADDR_W-1:0] BUSY_ADDR = 12'h168;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ------------------------------------------------------------
  // configuration fields
  // ------------------------------------------------------------
  localparam int CFG_PWM_BIT = 0;
  localparam int CFG_DUTY_BIT = 1;
  localparam int CFG_DIR_BIT = 2;
  localparam int CFG_STATE_LSB = 4;
  localparam int CFG_SEL_LSB = 8;

  typedef enum logic [1:0] {
    GPIO_OFF,
    GPIO_ON,
    GPIO_PULSE_ON,
    GPIO_PULSE_OFF
  } gpio_state_type;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
  localparam logic [TIME_W-1:0] LO_RST = 16'h0384;
  localparam logic [TIME_W-1:0] HI_RST = 16'h0834;
  localparam logic [TIME_W-1:0] WIDTH_RST = 16'h0000;
  localparam logic [TIME_W-1:0] PERIOD_RST = 16'h4e20;
  localparam logic [PCT_W-1:0] CMD_RST = 16'h0000;

endpackage

// File: hw/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
  import pwm_gpio_pkg::*;
  logic is_pwm;
  logic duty_mode;
  gpio_state_type state;
  logic fire;
  logic [TIME_W-1:0] lo_us;
  logic [TIME_W-1:0] hi_us;
  logic [TIME_W-1:0] width_us;
  logic [TIME_W-1:0] period_us;
  logic [TIME_W-1:0] phase_us;
  logic [PCT_W-1:0] pct;
  logic level;
  logic busy;
  modport ctl (output is_pwm, duty_mode, state, fire, lo_us, hi_us,
    width_us, period_us, phase_us, pct, input level, busy);
  modport chan (input is_pwm, duty_mode, state, fire, lo_us, hi_us,
    width_us, period_us, phase_us, pct, output level, busy);
endinterface // chan_if

// File: hw/pair_period_timer.sv
`timescale 1ns/1ps
module pair_period_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic [pwm_gpio_pkg::TIME_W-1:0] period_us,
  output logic [pwm_gpio_pkg::TIME_W-1:0] phase_us
);
  import pwm_gpio_pkg::*;

  logic [TIME_W-1:0] phase_q;
  wire at_end = (phase_q + 16'h0001) >= period_us;

  // one phase counter serves both channels of a pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= '0;
    end else if (period_us == '0) begin
      phase_q <= '0;
    end else if (tick) begin
      phase_q <= at_end ? '0 : phase_q + 16'h0001; // R12 R15
    end
  end

  assign phase_us = phase_q;

endmodule // pair_period_timer

// File: hw/channel_out.sv
`timescale 1ns/1ps
module channel_out (
  input wire logic hclk,
  input wire logic hresetn,
  chan_if.chan cif
);
  import pwm_gpio_pkg::*;

  // ------------------------------------------------------------
  // pulse width arithmetic
  // ------------------------------------------------------------
  wire [PCT_W-1:0] pct_c = (cif.pct > PCT_FULL) ? PCT_FULL : cif.pct;
  wire [TIME_W-1:0] span = (cif.hi_us > cif.lo_us) ?
    cif.hi_us - cif.lo_us : '0;
  wire [TIME_W+PCT_W-1:0] prod_pos = span * pct_c; // R8
  wire [TIME_W+PCT_W-1:0] quot_pos = prod_pos / PCT_FULL;
  wire [TIME_W-1:0] width_pos = cif.lo_us + quot_pos[TIME_W-1:0]; // R7
  wire [TIME_W+PCT_W-1:0] prod_duty = cif.period_us * pct_c; // R9
  wire [TIME_W+PCT_W-1:0] quot_duty = prod_duty / PCT_FULL;
  wire [TIME_W-1:0] width_duty = quot_duty[TIME_W-1:0];
  wire duty_level = (pct_c == PCT_FULL) ? 1'b1 : // R10
    (pct_c == '0) ? 1'b0 : // R11
    (cif.phase_us < width_duty);
  wire pos_level = (cif.period_us != '0) && (cif.phase_us < width_pos);
  wire pwm_level = cif.duty_mode ? duty_level : pos_level;

  // ------------------------------------------------------------
  // single timed pulse
  // ------------------------------------------------------------
  logic [TIME_W-1:0] rem_q;
  logic [TICK_W-1:0] sub_q;
  logic level_q;
  logic gpio_level;
  wire busy = rem_q != '0;
  wire sub_end = sub_q == TICK_LAST;

  // own sub-microsecond counter, restarted on fire, keeps width exact
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem_q <= '0;
      sub_q <= '0;
    end else if (cif.fire) begin
      rem_q <= cif.width_us; // R5 R6 R15
      sub_q <= '0;
    end else if (busy) begin
      sub_q <= sub_end ? '0 : sub_q + 8'h01;
      if (sub_end) rem_q <= rem_q - 16'h0001;
    end
  end

  always_comb begin
    case (cif.state) // R3
      GPIO_ON: gpio_level = 1'b1;
      GPIO_OFF: gpio_level = 1'b0; // R4
      GPIO_PULSE_ON: gpio_level = busy; // R5 R16
      GPIO_PULSE_OFF: gpio_level = ~busy; // R6 R16
      default: gpio_level = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) level_q <= 1'b0;
    else level_q <= cif.is_pwm ? pwm_level : gpio_level; // R1
  end

  assign cif.level = level_q;
  assign cif.busy = busy;

endmodule // channel_out

// File: hw/paired_pwm_gpio_outputs.sv
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module paired_pwm_gpio_outputs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [pwm_gpio_pkg::NUM_CH-1:0] pin_i,
  output logic [pwm_gpio_pkg::NUM_CH-1:0] pin_o,
  output logic [pwm_gpio_pkg::NUM_CH-1:0] pin_oe_n
);
  import pwm_gpio_pkg::*;

  // ------------------------------------------------------------
  // bus slave: address and data phase
  // ------------------------------------------------------------
  logic wr_pend_q;
  logic rd_wait_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_word;

  // only whole-word transfers are taken
  wire accept = hsel && hready && htrans[1] && (hsize == SIZE_WORD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end else begin
      if (accept) addr_q <= haddr[ADDR_W-1:0];
      wr_pend_q <= accept && hwrite;
      rd_wait_q <= accept && !hwrite;
    end
  end

  // one wait state per read so the answer comes from a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_q <= '0;
    else if (rd_wait_q) hrdata_q <= rd_word;
  end

  assign hrdata = hrdata_q;
  assign hreadyout = !rd_wait_q;
  assign hresp = 1'b0;

  wire wr_en = wr_pend_q && (addr_q[1:0] == 2'b00);

  // ------------------------------------------------------------
  // microsecond tick
  // ------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_q;
  wire tick = tick_cnt_q == TICK_LAST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_q <= '0;
    else tick_cnt_q <= tick ? '0 : tick_cnt_q + 8'h01; // R15
  end

  // ------------------------------------------------------------
  // register arrays; all but phase_a and drive_v are seen by the read path
  // ------------------------------------------------------------
  logic [CFG_W-1:0] cfg_a [NUM_CH];
  logic [TIME_W-1:0] lo_a [NUM_CH];
  logic [TIME_W-1:0] hi_a [NUM_CH];
  logic [TIME_W-1:0] width_a [NUM_CH];
  logic [PCT_W-1:0] cmd_a [NUM_CH];
  logic [TIME_W-1:0] period_a [NUM_PAIR];
  logic [TIME_W-1:0] phase_a [NUM_PAIR];
  logic [NUM_CH-1:0] level_v;
  logic [NUM_CH-1:0] busy_v;
  logic [NUM_CH-1:0] drive_v;
  logic [NUM_CH-1:0] pin_in_q;

  // ------------------------------------------------------------
  // actuator commands
  // ------------------------------------------------------------
  for (genvar a = 0; a < NUM_CH; a++) begin : g_cmd
    logic [PCT_W-1:0] cmd_q;
    wire wr_cmd = wr_en &&
      (addr_q == ADDR_W'(int'(CMD_BASE) + a * 4));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cmd_q <= CMD_RST;
      else if (wr_cmd) cmd_q <= hwdata[PCT_W-1:0];
    end

    assign cmd_a[a] = cmd_q;
  end

  // ------------------------------------------------------------
  // shared pair periods
  // ------------------------------------------------------------
  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
    logic [TIME_W-1:0] period_q;
    wire wr_per = wr_en &&
      (addr_q == ADDR_W'(int'(PERIOD_BASE) + p * 4));

    // one register per pair: writing it changes both channels
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) period_q <= PERIOD_RST;
      else if (wr_per) period_q <= hwdata[TIME_W-1:0]; // R13
    end

    pair_period_timer u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick),
      .period_us(period_q),
      .phase_us(phase_a[p])
    );

    assign period_a[p] = period_q;
  end

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  chan_if cif [NUM_CH] ();

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam int BASE = i * CH_STRIDE;
    logic [CFG_W-1:0] cfg_q;
    logic [TIME_W-1:0] lo_q;
    logic [TIME_W-1:0] hi_q;
    logic [TIME_W-1:0] width_q;
    logic fire_q;
    wire wr_cfg = wr_en && (addr_q == ADDR_W'(BASE + OFS_CFG));
    wire wr_lo = wr_en && (addr_q == ADDR_W'(BASE + OFS_LO));
    wire wr_hi = wr_en && (addr_q == ADDR_W'(BASE + OFS_HI));
    wire wr_wid = wr_en && (addr_q == ADDR_W'(BASE + OFS_WIDTH));
    wire [1:0] new_state = hwdata[CFG_STATE_LSB +: 2];
    wire new_pulse = (new_state == GPIO_PULSE_ON) ||
      (new_state == GPIO_PULSE_OFF);
    wire [SEL_W-1:0] sel = cfg_q[CFG_SEL_LSB +: SEL_W];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_q <= CFG_RST;
        lo_q <= LO_RST;
        hi_q <= HI_RST;
        width_q <= WIDTH_RST;
      end else begin
        if (wr_cfg) cfg_q <= hwdata[CFG_W-1:0]; // R1 R2 R3
        if (wr_lo) lo_q <= hwdata[TIME_W-1:0]; // R7
        if (wr_hi) hi_q <= hwdata[TIME_W-1:0]; // R7
        if (wr_wid) width_q <= hwdata[TIME_W-1:0];
      end
    end

    // each write of a pulse state with the PWM bit clear starts a fresh pulse
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) fire_q <= 1'b0;
      else fire_q <= wr_cfg && !hwdata[CFG_PWM_BIT] && new_pulse;
    end

    assign cif[i].is_pwm = cfg_q[CFG_PWM_BIT];
    assign cif[i].duty_mode = cfg_q[CFG_DUTY_BIT];
    assign cif[i].state = gpio_state_type'(cfg_q[CFG_STATE_LSB +: 2]);
    assign cif[i].fire = fire_q;
    assign cif[i].lo_us = lo_q;
    assign cif[i].hi_us = hi_q;
    assign cif[i].width_us = width_q;
    assign cif[i].period_us = period_a[i / 2]; // R13
    assign cif[i].phase_us = phase_a[i / 2]; // R13
    assign cif[i].pct = cmd_a[sel]; // R14

    channel_out u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .cif(cif[i])
    );

    assign cfg_a[i] = cfg_q;
    assign lo_a[i] = lo_q;
    assign hi_a[i] = hi_q;
    assign width_a[i] = width_q;
    assign level_v[i] = cif[i].level;
    assign busy_v[i] = cif[i].busy;
    // PWM channels always drive; GPIO drives only as an output
    assign drive_v[i] = cfg_q[CFG_PWM_BIT] || cfg_q[CFG_DIR_BIT]; // R2
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pin_in_q <= '0;
    else pin_in_q <= pin_i;
  end

  assign pin_o = level_v;
  assign pin_oe_n = ~drive_v; // R2

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  wire aligned = addr_q[1:0] == 2'b00;
  wire in_ch = addr_q < CMD_BASE;
  wire in_cmd = (addr_q >= CMD_BASE) && (addr_q < PERIOD_BASE);
  wire in_per = (addr_q >= PERIOD_BASE) && (addr_q < PIN_IN_ADDR);
  wire [3:0] rd_ch = addr_q[7:4];
  wire [1:0] rd_reg = addr_q[3:2];
  wire [3:0] rd_cmd = addr_q[5:2];
  wire [2:0] rd_per = addr_q[4:2];

  wire [31:0] ch_word =
    (rd_reg == 2'h0) ? {20'h00000, cfg_a[rd_ch]} :
    (rd_reg == 2'h1) ? {16'h0000, lo_a[rd_ch]} :
    (rd_reg == 2'h2) ? {16'h0000, hi_a[rd_ch]} :
    {16'h0000, width_a[rd_ch]};

  wire [31:0] map_word =
    in_ch ? ch_word :
    in_cmd ? {16'h0000, cmd_a[rd_cmd]} :
    in_per ? {16'h0000, period_a[rd_per]} :
    (addr_q == PIN_IN_ADDR) ? {16'h0000, pin_in_q} :
    (addr_q == PIN_OUT_ADDR) ? {16'h0000, level_v} :
    (addr_q == BUSY_ADDR) ? {16'h0000, busy_v} :
    32'h00000000;

  assign rd_word = aligned ? map_word : 32'h00000000;

endmodule // paired_pwm_gpio_outputs

// File: test/pwm_gpio_chk.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus and pin checks seen at the top ports
// ------------------------------------------------------------
module pwm_gpio_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [pwm_gpio_pkg::NUM_CH-1:0] pin_i,
  input wire logic [pwm_gpio_pkg::NUM_CH-1:0] pin_o,
  input wire logic [pwm_gpio_pkg::NUM_CH-1:0] pin_oe_n
);
  import pwm_gpio_pkg::*;
  logic wr_q;
  wire take = hsel && hready && htrans[1];
  wire word = hsize == SIZE_WORD;
  wire rd_take = take && word && !hwrite;
  wire wr_take = take && word && hwrite;
  wire odd_take = take && !word;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_q <= 1'b0;
    else wr_q <= wr_take;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_read_wait; rd_take |=> s_one_wait; endproperty
  property p_write_nowait; wr_take |=> hreadyout; endproperty
  property p_narrow_nowait; odd_take |=> hreadyout; endproperty
  property p_single_wait; !hreadyout |=> hreadyout; endproperty
  property p_wait_cause; !hreadyout |-> $past(rd_take); endproperty
  property p_rdata_hold; hreadyout |=> $stable(hrdata); endproperty
  property p_resp_okay; 1'b1 |-> !hresp; endproperty
  property p_oe_cause; $changed(pin_oe_n) |-> $past(wr_q); endproperty
  property p_narrow_drop;
    odd_take && hwrite |=> ##1 $stable(pin_oe_n);
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (p_write_nowait)
    else $error("write stalled");
  a_narrow_nowait: assert property (p_narrow_nowait)
    else $error("narrow access stalled");
  a_single_wait: assert property (p_single_wait)
    else $error("wait longer than one cycle");
  a_wait_cause: assert property (p_wait_cause)
    else $error("wait without read");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  a_resp_okay: assert property (p_resp_okay)
    else $error("error response");
  a_oe_cause: assert property (p_oe_cause)
    else $error("enable moved without write");
  a_narrow_drop: assert property (p_narrow_drop)
    else $error("narrow write changed enables");
endmodule // pwm_gpio_chk

bind paired_pwm_gpio_outputs pwm_gpio_chk pwm_gpio_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n));

// File: test/servo_load.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// actuator load: drives undriven pins, times runs of one pin
// ------------------------------------------------------------
module servo_load (
  input wire logic hclk,
  input wire logic [pwm_gpio_pkg::NUM_CH-1:0] pin_o,
  input wire logic [pwm_gpio_pkg::NUM_CH-1:0] pin_oe_n,
  input wire logic [pwm_gpio_pkg::NUM_CH-1:0] drv,
  input wire logic [3:0] sel,
  output logic [pwm_gpio_pkg::NUM_CH-1:0] pin_w,
  output logic [31:0] hi_cyc,
  output logic [31:0] lo_cyc,
  output logic [31:0] run_cyc,
  output logic lvl
);
  import pwm_gpio_pkg::*;
  assign pin_w = (~pin_oe_n & pin_o) | (pin_oe_n & drv);
  initial begin
    hi_cyc = 0;
    lo_cyc = 0;
    run_cyc = 0;
    lvl = 1'b0;
  end
  // run lengths in block clock cycles
  always @(posedge hclk) begin
    if (pin_o[sel] === lvl) run_cyc <= run_cyc + 1;
    else begin
      if (lvl) hi_cyc <= run_cyc;
      else lo_cyc <= run_cyc;
      run_cyc <= 1;
      lvl <= pin_o[sel];
    end
  end
endmodule // servo_load

// File: test/tb_paired_pwm_gpio_outputs.sv
`timescale 1ns/1ps
module tb_paired_pwm_gpio_outputs;
  import pwm_gpio_pkg::*;
  logic hclk = 1'b0, hresetn, hsel, hwrite, rd_pend = 1'b0, lvl;
  logic [31:0] haddr, hwdata, hrdata, seed, hi_cyc, lo_cyc, run_cyc;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  logic [NUM_CH-1:0] pin_w, pin_o, pin_oe_n, drv;
  logic [3:0] sel;
  logic [31:0] expq[$];
  int miscompares = 0, samples_checked = 0, i;
  always #2 hclk = ~hclk;
  paired_pwm_gpio_outputs paired_pwm_gpio_outputs_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_i(pin_w),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n));
  servo_load servo_load_i (.hclk(hclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .drv(drv), .sel(sel), .pin_w(pin_w), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc),
    .run_cyc(run_cyc), .lvl(lvl));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      complete_run;
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, input logic [2:0] s);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    xfer(1'b1, 32'(a), d, SIZE_WORD);
  endtask
  task automatic rd(input int a, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, 32'(a), 32'h0, SIZE_WORD);
  endtask
  // read results compared against the oldest note
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      rd_pend = 1'b0;
      if (expq.size() > 0) check("hrdata", hrdata, expq.pop_front());
      else miscompares++;
    end
    if (hsel === 1'b1 && htrans[1] === 1'b1 && hwrite === 1'b0 &&
      hsize === SIZE_WORD && hreadyout === 1'b1) rd_pend = 1'b1;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, drv, sel} = '0;
    hsize = SIZE_WORD;
    seed = 32'hfe58563a;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < NUM_CH; i++) begin
      rd(i * CH_STRIDE + OFS_CFG, 32'(CFG_RST));
      rd(i * CH_STRIDE + OFS_LO, 32'(LO_RST));
      rd(i * CH_STRIDE + OFS_HI, 32'(HI_RST));
      rd(i * CH_STRIDE + OFS_WIDTH, 32'(WIDTH_RST));
      rd(CMD_BASE + 4 * i, 32'(CMD_RST));
    end
    for (i = 0; i < NUM_PAIR; i++) rd(PERIOD_BASE + 4 * i, 32'(PERIOD_RST));
    rd(12'h16c, 32'h0);
    seed = lfsr(seed);
    wr(OFS_LO, seed);
    rd(OFS_LO, {16'h0, seed[15:0]});
    for (i = 0; i < NUM_CH; i++) wr(i * CH_STRIDE, 32'h14);
    // the last enable lands at this edge; look once it has settled
    @(posedge hclk);
    check("oe_on", 32'(pin_oe_n), 32'h0);
    rd(PIN_OUT_ADDR, 32'h0000ffff);
    seed = lfsr(seed);
    drv <= seed[15:0];
    for (i = 0; i < NUM_CH; i++) wr(i * CH_STRIDE, 32'h0);
    rd(PIN_IN_ADDR, {16'h0, seed[15:0]});
    check("oe_in", 32'(pin_oe_n), 32'h0000ffff);
    xfer(1'b1, 32'h0, 32'h14, 3'h0);
    xfer(1'b0, 32'h0, 32'h0, 3'h0);
    check("oe_narrow", 32'(pin_oe_n[0]), 32'h1);
    wr(0, 32'h04);
    rd(PIN_OUT_ADDR, 32'h0);
    sel <= 4'h1;
    wr(CH_STRIDE + OFS_WIDTH, 32'h3);
    wr(CH_STRIDE, 32'h24);
    rd(BUSY_ADDR, 32'h2);
    repeat (1000) @(posedge hclk);
    check("pulse_hi", hi_cyc, 32'(3 * TICK_CYCLES));
    rd(PIN_OUT_ADDR, 32'h0);
    wr(CH_STRIDE, 32'h14);
    wr(CH_STRIDE, 32'h34);
    repeat (1000) @(posedge hclk);
    check("pulse_lo", lo_cyc, 32'(3 * TICK_CYCLES));
    rd(PIN_OUT_ADDR, 32'h2);
    sel <= 4'h2;
    wr(PERIOD_BASE + 4, 32'd40);
    wr(CMD_BASE + 8, 32'd2500);
    wr(2 * CH_STRIDE, 32'h203);
    repeat (20000) @(posedge hclk);
    check("duty_hi", hi_cyc, 32'(40 * 2500 / 10000 * TICK_CYCLES));
    check("duty_lo", lo_cyc, 32'(30 * TICK_CYCLES));
    wr(CMD_BASE + 8, 32'(PCT_FULL));
    repeat (12000) @(posedge hclk);
    check("full", {lvl, run_cyc > 10000}, 32'h3);
    wr(CMD_BASE + 8, 32'h0);
    repeat (12000) @(posedge hclk);
    check("zero", {lvl, run_cyc > 10000}, 32'h1);
    sel <= 4'h3;
    wr(3 * CH_STRIDE + OFS_LO, 32'd10);
    wr(3 * CH_STRIDE + OFS_HI, 32'd30);
    wr(CMD_BASE + 20, 32'd5000);
    wr(3 * CH_STRIDE, 32'h501);
    repeat (20000) @(posedge hclk);
    check("pos_hi", hi_cyc, 32'((10 + 20 * 5000 / 10000) * TICK_CYCLES));
    check("pos_lo", lo_cyc, 32'(20 * TICK_CYCLES));
    repeat (5) @(posedge hclk);
    complete_run;
  end
endmodule // tb_paired_pwm_gpio_outputs
